/* File: logic/pdlr_pkg.sv */
// Constants and types of the default loader and EEPROM arbiter.
`default_nettype none
package pdlr_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_NS = 750;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DIV_RELOAD = 8'(SCLK_HALF_CYC - 1);
  localparam logic [7:0] ADDR_FIRST = 8'h00;
  localparam logic [7:0] ADDR_LAST = 8'h0D;
  localparam logic [7:0] ADDR_RESOURCE = 8'h0E;
  localparam int ADDR_MEMB = 0;
  localparam int ADDR_MEMU = 2;
  localparam int ADDR_IOB = 4;
  localparam int ADDR_SIZE = 9;
  localparam int ADDR_IRQA = 10;
  localparam int ADDR_IRQB = 11;
  localparam int ADDR_ACT = 12;
  localparam int ADDR_DMAMAP = 13;
  localparam int NUM_WORDS = 14;
  localparam logic [2:0] CMD_READ = 3'h6;
  localparam logic [4:0] CMD_LAST = 5'h0A;
  localparam logic [4:0] BIT_LAST = 5'h1B;
  localparam int NUM_UNITS = 5;
  localparam int MODE0_UNITS = 2;
  localparam int MODE0_PAIRS = 3;
  localparam int SIZE_LSB0 = 13;
  localparam int SIZE_STEP = 3;
  localparam int IRQ_LSB0 = 12;
  localparam int IRQ_STEP = 4;
  localparam int IRQ4_LSB = 12;
  localparam int DMA0_LSB = 9;
  localparam int DMA1_LSB = 6;
  localparam int ACT_BIT0 = 15;
  localparam int OEN_A_LSB = 8;
  localparam int OEN_B_LSB = 5;
  localparam int MODE_BIT = 4;
  localparam int MAP_STEP = 3;
  localparam logic [2:0] SIZE_MAX = 3'h6;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] CSN_RESET = 8'h00;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_BOARD, ST_SETUP, ST_XFER, ST_GAP, ST_APPLY} pdlr_state_type;
endpackage
`default_nettype wire

/* File: logic/pdlr_loader.sv */
// Power-up default loader with serial EEPROM sharing handshake.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mode 1 serves five units and five device DMA channel pairs.
// - Mode 0 routes DMA requests to three device channel pairs.
// - Reset clears state, loads defaults, enters wait-for-key, zeroes card select number.
// - On reset the device claims the EEPROM and raises its claim output.
// - After loading, release all EEPROM pins, enter wait-for-key, drop claim.
// - Device drives the EEPROM only after the board request has fallen.
// - A wake command reads word 0x0E, start of resource data.
// - Each read is opcode, address, one dummy bit, then sixteen data bits.
// - Defaults come from words 0x00 to 0x0D after reset.
// - Words 0x00-0x03 give memory base and upper bits; ignored in mode 1.
// - Words 0x04-0x08 give unit I/O bases; units 2-4 ignored in mode 0.
// - Word 0x09 holds five 3-bit block sizes; bits 9-1 ignored mode 0.
// - Word 0x0A holds IRQ levels units 0-3; bits 7-0 ignored mode 0.
// - Word 0x0B holds unit 4 IRQ and DMA channels of units 0, 1.
// - Word 0x0C holds active bits, two read-enable selectors and mode bit.
// - Mode 0 ignores bits 13-11 and 7-5 of word 0x0C.
// - Word 0x0D holds five DMA mappings; bits 14-9 ignored in mode 0.
// - Size codes 0-6 select 1 to 64 byte blocks for address compare.
// - Mode 0 selector A: code 0 unit 0, 1 unit 1, 2 either.
// - Mode 1 each selector answers reads of the unit numbered by code.
// - IRQ and DMA fields are plain binary ISA numbers.
// - Active bit set makes the unit active after reset; clear keeps inactive.
// - Mode bit 0 selects mode 0, 1 selects mode 1.
// - Each mapping field names the ISA channel served by its device pair.
module pdlr_loader (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic board_rom_claim_i,
  input wire logic wake_i,
  input wire logic rom_serial_line_i,
  input wire logic io_read_i,
  input wire logic [15:0] io_addr_i,
  output logic device_rom_claim_o,
  output logic rom_select_o,
  output logic rom_select_oe_n_o,
  output logic rom_clock_o,
  output logic rom_clock_oe_n_o,
  output logic rom_serial_line_o,
  output logic rom_serial_line_oe_n_o,
  output logic wait_for_key_o,
  output logic [7:0] card_select_number_o,
  output logic mode_o,
  output logic [1:0][15:0] mem_base_o,
  output logic [1:0][15:0] mem_upper_o,
  output logic [pdlr_pkg::NUM_UNITS-1:0][15:0] io_base_o,
  output logic [pdlr_pkg::NUM_UNITS-1:0][2:0] io_size_o,
  output logic [pdlr_pkg::NUM_UNITS-1:0][3:0] irq_level_o,
  output logic [1:0][2:0] dma_channel_o,
  output logic [pdlr_pkg::NUM_UNITS-1:0] active_o,
  output logic [pdlr_pkg::NUM_UNITS-1:0][2:0] dma_map_o,
  output logic [pdlr_pkg::NUM_UNITS-1:0] dma_pair_enable_o,
  output logic read_enable_out_a_o,
  output logic read_enable_out_b_o,
  output logic [15:0] resource_word_o,
  output logic resource_valid_o
);
  import pdlr_pkg::*;
  pdlr_state_type state_r;
  logic [7:0] div_r;
  logic tick;
  logic [4:0] bit_cnt_r;
  logic [10:0] cmd_r;
  logic [15:0] shift_r;
  logic [7:0] word_addr_r;
  logic res_r;
  logic [15:0] words_r [0:NUM_WORDS-1];
  logic board_m_r, board_q_r, sio_m_r, sio_q_r, ior_m_r, ior_q_r;
  logic [15:0] addr_m_r, addr_q_r;
  logic mode_sel;
  logic [NUM_UNITS-1:0] hit;
  logic [2:0] oen_a_code, oen_b_code;
  logic sel_a, sel_b;
  // Pins from outside the clock domain pass two flip-flops before use.
  always_ff @(posedge clk_i)
  begin
    {board_q_r, board_m_r} <= {board_m_r, board_rom_claim_i};
    {sio_q_r, sio_m_r} <= {sio_m_r, rom_serial_line_i};
    {ior_q_r, ior_m_r} <= {ior_m_r, io_read_i};
    {addr_q_r, addr_m_r} <= {addr_m_r, io_addr_i};
  end
  // The half-period divider runs only while a transaction owns the pins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_r == ST_IDLE || state_r == ST_WAIT_BOARD || state_r == ST_APPLY || div_r == 8'h00)
      div_r <= DIV_RELOAD;
    else
      div_r <= div_r - 8'h01;
  end
  assign tick = (div_r == 8'h00);
  // Serial read sequencer and ownership handshake.
  always_ff @(posedge clk_i)
  begin
    resource_valid_o <= 1'b0;
    if (rst_i)
    begin
      state_r <= ST_WAIT_BOARD;
      device_rom_claim_o <= 1'b1;
      wait_for_key_o <= 1'b1;
      word_addr_r <= ADDR_FIRST;
      res_r <= 1'b0;
      {rom_select_o, rom_clock_o, rom_serial_line_o} <= 3'h0;
      {rom_select_oe_n_o, rom_clock_oe_n_o, rom_serial_line_oe_n_o} <= 3'h7;
      resource_word_o <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (wake_i)
          begin
            device_rom_claim_o <= 1'b1;
            wait_for_key_o <= 1'b0;
            res_r <= 1'b1;
            word_addr_r <= ADDR_RESOURCE;
            state_r <= ST_WAIT_BOARD;
          end
        end
        ST_WAIT_BOARD:
        begin
          // The board keeps the pins until its request falls.
          if (!board_q_r)
          begin
            state_r <= ST_SETUP;
            cmd_r <= {CMD_READ, word_addr_r};
            bit_cnt_r <= 5'h00;
            rom_select_o <= 1'b1;
            rom_clock_o <= 1'b0;
            rom_serial_line_o <= CMD_READ[2];
            {rom_select_oe_n_o, rom_clock_oe_n_o, rom_serial_line_oe_n_o} <= 3'h0;
          end
        end
        ST_SETUP:
        begin
          if (tick)
          begin
            rom_clock_o <= 1'b1;
            state_r <= ST_XFER;
          end
        end
        ST_XFER:
        begin
          if (tick)
          begin
            rom_clock_o <= ~rom_clock_o;
            if (rom_clock_o)
            begin
              // Sampling on the falling edge leaves a full half period for the EEPROM output.
              shift_r <= {shift_r[14:0], sio_q_r};
              cmd_r <= {cmd_r[9:0], 1'b0};
              rom_serial_line_o <= (bit_cnt_r == CMD_LAST) ? 1'b0 : cmd_r[9];
              if (bit_cnt_r == CMD_LAST)
                rom_serial_line_oe_n_o <= 1'b1;
              if (bit_cnt_r == BIT_LAST)
              begin
                rom_select_o <= 1'b0;
                state_r <= ST_GAP;
              end
              else
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
          end
        end
        ST_GAP:
        begin
          if (tick)
            state_r <= ST_APPLY;
        end
        ST_APPLY:
        begin
          // Pins are let go between words, so a late board request never finds them driven.
          {rom_select_oe_n_o, rom_clock_oe_n_o, rom_serial_line_oe_n_o} <= 3'h7;
          if (res_r)
          begin
            resource_word_o <= shift_r;
            resource_valid_o <= 1'b1;
          end
          if (res_r || word_addr_r == ADDR_LAST)
          begin
            state_r <= ST_IDLE;
            res_r <= 1'b0;
            device_rom_claim_o <= 1'b0;
            wait_for_key_o <= !res_r;
          end
          else
          begin
            word_addr_r <= word_addr_r + 8'h01;
            state_r <= ST_WAIT_BOARD;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
  // Raw default image, one flip-flop word per EEPROM address.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_WORDS; i++)
        words_r[i] <= WORD_RESET;
    end
    else if (state_r == ST_APPLY && !res_r)
      words_r[word_addr_r[3:0]] <= shift_r;
  end
  assign mode_sel = words_r[ADDR_ACT][MODE_BIT];
  // Decoded configuration; fields ignored in the current mode read as zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      card_select_number_o <= CSN_RESET;
    mode_o <= mode_sel;
    for (int m = 0; m < 2; m++)
    begin
      mem_base_o[m] <= mode_sel ? 16'h0000 : words_r[ADDR_MEMB + m];
      mem_upper_o[m] <= mode_sel ? 16'h0000 : words_r[ADDR_MEMU + m];
    end
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      if (mode_sel || u < MODE0_UNITS)
      begin
        io_base_o[u] <= words_r[ADDR_IOB + u];
        io_size_o[u] <= words_r[ADDR_SIZE][SIZE_LSB0 - SIZE_STEP * u +: 3];
        active_o[u] <= words_r[ADDR_ACT][ACT_BIT0 - u];
      end
      else
      begin
        io_base_o[u] <= 16'h0000;
        io_size_o[u] <= 3'h0;
        active_o[u] <= 1'b0;
      end
      if (u == NUM_UNITS - 1)
        irq_level_o[u] <= mode_sel ? words_r[ADDR_IRQB][IRQ4_LSB +: 4] : 4'h0;
      else if (mode_sel || u < MODE0_UNITS)
        irq_level_o[u] <= words_r[ADDR_IRQA][IRQ_LSB0 - IRQ_STEP * u +: 4];
      else
        irq_level_o[u] <= 4'h0;
      dma_pair_enable_o[u] <= mode_sel || u < MODE0_PAIRS;
      dma_map_o[u] <= (mode_sel || u < MODE0_PAIRS) ? words_r[ADDR_DMAMAP][MAP_STEP * u +: 3] : 3'h0;
    end
    dma_channel_o[0] <= words_r[ADDR_IRQB][DMA0_LSB +: 3];
    dma_channel_o[1] <= words_r[ADDR_IRQB][DMA1_LSB +: 3];
  end
  assign oen_a_code = words_r[ADDR_ACT][OEN_A_LSB +: 3];
  assign oen_b_code = words_r[ADDR_ACT][OEN_B_LSB +: 3];
  // Block hit: address bits below log2 of the block size are not compared.
  always_comb
  begin
    for (int u = 0; u < NUM_UNITS; u++)
      hit[u] = active_o[u] && (((addr_q_r ^ io_base_o[u]) >> ((io_size_o[u] > SIZE_MAX) ? SIZE_MAX : io_size_o[u])) == 16'h0000);
  end
  always_comb
  begin
    sel_a = 1'b0;
    sel_b = 1'b0;
    if (mode_sel)
    begin
      if (oen_a_code < 3'(NUM_UNITS))
        sel_a = hit[oen_a_code];
      if (oen_b_code < 3'(NUM_UNITS))
        sel_b = hit[oen_b_code];
    end
    else
    begin
      case (oen_a_code)
        3'h0: sel_a = hit[0];
        3'h1: sel_a = hit[1];
        3'h2: sel_a = hit[0] | hit[1];
        default: sel_a = 1'b0;
      endcase
    end
  end
  // Read enables follow the synchronised read strobe; selector B stays idle in mode 0.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {read_enable_out_a_o, read_enable_out_b_o} <= 2'h0;
    else
      {read_enable_out_a_o, read_enable_out_b_o} <= {ior_q_r && sel_a, ior_q_r && sel_b};
  end
  property p_reset_claim;
    @(posedge clk_i) rst_i |=> device_rom_claim_o && wait_for_key_o && card_select_number_o == 8'h00;
  endproperty
  a_reset_claim: assert property (p_reset_claim) else $error("Claim or state wrong after reset.");
  property p_release;
    @(posedge clk_i) disable iff (rst_i)
      $fell(device_rom_claim_o) |-> rom_select_oe_n_o && rom_clock_oe_n_o && rom_serial_line_oe_n_o;
  endproperty
  a_release: assert property (p_release) else $error("Pins still driven after claim dropped.");
  property p_hold_off;
    @(posedge clk_i) disable iff (rst_i) (state_r == ST_WAIT_BOARD && board_q_r) |=> rom_select_oe_n_o;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("EEPROM driven while board holds it.");
  property p_grant;
    @(posedge clk_i) disable iff (rst_i) (state_r == ST_WAIT_BOARD && !board_q_r) |=> !rom_select_oe_n_o && rom_select_o;
  endproperty
  a_grant: assert property (p_grant) else $error("Select not raised after board release.");
  property p_wake_addr;
    @(posedge clk_i) disable iff (rst_i) (state_r == ST_IDLE && wake_i) |=> word_addr_r == ADDR_RESOURCE && res_r;
  endproperty
  a_wake_addr: assert property (p_wake_addr) else $error("Wake read not at resource start.");
  property p_bit_count;
    @(posedge clk_i) disable iff (rst_i) (state_r == ST_XFER ##1 state_r == ST_GAP) |-> $past(bit_cnt_r) == BIT_LAST;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("Read length wrong.");
  property p_ascend;
    @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_APPLY && !res_r && word_addr_r != ADDR_LAST) |=> word_addr_r == $past(word_addr_r) + 8'h01 && device_rom_claim_o;
  endproperty
  a_ascend: assert property (p_ascend) else $error("Default words not read in order.");
  property p_mode1_mem;
    @(posedge clk_i) disable iff (rst_i) mode_o && $past(mode_o) |-> mem_base_o == 32'h0000_0000 && mem_upper_o == 32'h0000_0000;
  endproperty
  a_mode1_mem: assert property (p_mode1_mem) else $error("Memory fields used in mode 1.");
  property p_mode0_units;
    @(posedge clk_i) disable iff (rst_i) !mode_o && !$past(mode_o) |-> active_o[4:2] == 3'h0 && io_base_o[2] == 16'h0000 && !read_enable_out_b_o;
  endproperty
  a_mode0_units: assert property (p_mode0_units) else $error("Mode 0 used unit 2 to 4 fields.");
  property p_oen_a;
    @(posedge clk_i) disable iff (rst_i) (!mode_sel && oen_a_code == 3'h2 && ior_q_r && (hit[0] || hit[1])) |=> read_enable_out_a_o;
  endproperty
  a_oen_a: assert property (p_oen_a) else $error("Selector A missed a mode 0 read.");
  c_load_done: cover property (@(posedge clk_i) disable iff (rst_i) $fell(device_rom_claim_o) && wait_for_key_o);
  c_wake_read: cover property (@(posedge clk_i) disable iff (rst_i) resource_valid_o);
  c_board_wait: cover property (@(posedge clk_i) disable iff (rst_i) state_r == ST_WAIT_BOARD && board_q_r ##1 !board_q_r);
endmodule // pdlr_loader
`default_nettype wire

/* File: tb/pdlr_rom_model.sv */
// Behavioural serial EEPROM and board-side request logic facing the loader.
`timescale 1ns/1ps
`default_nettype none
module pdlr_rom_model
  import pdlr_pkg::*;
(
  input wire logic clk_i,
  input wire logic want_i,
  input wire logic claim_i,
  input wire logic sel_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic doe_o,
  output logic board_req_o,
  output logic [7:0] addr_o,
  output logic cmd_ok_o,
  output int reads_o
);
  // Unused and mode-ignored bits are set on purpose so that leaks show up.
  localparam logic [15:0] IMG [15] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h0100, 16'h0240, 16'h0280,
    16'h0300, 16'h0380, 16'h193B, 16'h3579, 16'hBAFF, 16'hF33F, 16'hE888, 16'hA55A};
  logic [15:0] mem [256];
  logic [10:0] sr = 11'h000;
  int k = 0;
  int hold = 40;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = (i < 15) ? IMG[i] : 16'hFFFF;
    dout_o = 1'b0;
    doe_o = 1'b0;
    board_req_o = 1'b0;
    addr_o = 8'h00;
    cmd_ok_o = 1'b1;
    reads_o = 0;
  end
  always @(posedge sclk_i)
  begin
    if (sel_i)
    begin
      if (k <= 10)
        sr = {sr[9:0], din_i};
      if (k == 10)
      begin
        addr_o = sr[7:0];
        cmd_ok_o = (sr[10:8] == CMD_READ);
        reads_o++;
      end
      doe_o = (k >= 11 && k <= 27);
      dout_o = (k >= 12 && k <= 27) ? mem[addr_o][27 - k] : 1'b0;
      k++;
    end
  end
  // A deselected part lets go of the line and the pulldown takes it low.
  always @(negedge sel_i)
  begin
    k = 0;
    doe_o = 1'b0;
    dout_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    if (!want_i)
      board_req_o <= 1'b0;
    else if (claim_i !== 1'b1)
    begin
      board_req_o <= 1'b1;
      hold <= 40;
    end
    else if (hold > 0)
      hold <= hold - 1;
    else
      board_req_o <= 1'b0;
  end
endmodule // pdlr_rom_model
`default_nettype wire

/* File: tb/pdlr_loader_test.sv */
// Self-checking bench for the loader: default load, read enables and wake read.
`timescale 1ns/1ps
`default_nettype none
module pdlr_loader_test;
  import pdlr_pkg::*;
  localparam logic [15:0] BASE_EXP [5] = '{16'h0100, 16'h0240, 16'h0280, 16'h0300, 16'h0380};
  localparam logic [2:0] SIZE_EXP [5] = '{3'h0, 3'h6, 3'h2, 3'h3, 3'h5};
  localparam logic [3:0] IRQ_EXP [5] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hB};
  localparam logic [2:0] MAP_EXP [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
  localparam logic [17:0] RD_TAB [6] = '{{16'h0300, 2'h2}, {16'h0307, 2'h2}, {16'h0308, 2'h0},
    {16'h027F, 2'h1}, {16'h0280, 2'h0}, {16'h023F, 2'h0}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wake_i = 1'b0;
  logic io_read_i = 1'b0;
  logic want = 1'b1;
  logic [15:0] io_addr_i = 16'h0000;
  logic board_rom_claim_i, rom_serial_line_i, mdo, mdoe, mcmd;
  logic device_rom_claim_o, rom_select_o, rom_select_oe_n_o, rom_clock_o, rom_clock_oe_n_o;
  logic rom_serial_line_o, rom_serial_line_oe_n_o, wait_for_key_o, mode_o, read_enable_out_a_o;
  logic read_enable_out_b_o, resource_valid_o;
  logic [7:0] card_select_number_o, maddr;
  logic [1:0][15:0] mem_base_o, mem_upper_o;
  logic [NUM_UNITS-1:0][15:0] io_base_o;
  logic [NUM_UNITS-1:0][2:0] io_size_o, dma_map_o;
  logic [NUM_UNITS-1:0][3:0] irq_level_o;
  logic [1:0][2:0] dma_channel_o;
  logic [NUM_UNITS-1:0] active_o, dma_pair_enable_o;
  logic [15:0] resource_word_o;
  int mreads;
  int error_cnt = 0;
  int samples_checked = 0;
  // Released pins fall to their pulldown level.
  wire sel_w = !rom_select_oe_n_o && rom_select_o;
  wire sclk_w = !rom_clock_oe_n_o && rom_clock_o;
  assign rom_serial_line_i = !rom_serial_line_oe_n_o ? rom_serial_line_o : (mdoe && mdo);
  always #2 clk_i = ~clk_i;
  pdlr_loader dut_u (.clk_i, .rst_i, .board_rom_claim_i, .wake_i, .rom_serial_line_i, .io_read_i, .io_addr_i,
    .device_rom_claim_o, .rom_select_o, .rom_select_oe_n_o, .rom_clock_o, .rom_clock_oe_n_o,
    .rom_serial_line_o, .rom_serial_line_oe_n_o, .wait_for_key_o, .card_select_number_o, .mode_o,
    .mem_base_o, .mem_upper_o, .io_base_o, .io_size_o, .irq_level_o, .dma_channel_o, .active_o, .dma_map_o,
    .dma_pair_enable_o, .read_enable_out_a_o, .read_enable_out_b_o, .resource_word_o, .resource_valid_o);
  pdlr_rom_model rom_u (.clk_i, .want_i(want), .claim_i(device_rom_claim_o), .sel_i(sel_w), .sclk_i(sclk_w),
    .din_i(rom_serial_line_i), .dout_o(mdo), .doe_o(mdoe), .board_req_o(board_rom_claim_i), .addr_o(maddr),
    .cmd_ok_o(mcmd), .reads_o(mreads));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic give_up();
    chk(16'h0000, 16'h0001);
    summarize();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic io_rd(input logic [15:0] a, input logic [1:0] e);
    io_addr_i = a;
    io_read_i = 1'b1;
    tick(5);
    chk(16'(read_enable_out_a_o), 16'(e[1]));
    chk(16'(read_enable_out_b_o), 16'(e[0]));
    io_read_i = 1'b0;
    tick(5);
  endtask
  initial
  begin
    int seen;
    seen = 0;
    tick(20);
    chk(16'(device_rom_claim_o), 16'h0001);
    chk(16'(wait_for_key_o), 16'h0001);
    chk(16'(card_select_number_o), 16'h0000);
    rst_i = 1'b0;
    // The board still holds the part, so the loader must keep its pins off.
    for (int n = 0; board_rom_claim_i === 1'b1; n++)
    begin
      chk(16'(rom_select_oe_n_o), 16'h0001);
      if (n > 100)
        give_up();
      tick(1);
    end
    for (int n = 0; rom_select_oe_n_o !== 1'b0; n++)
    begin
      if (n > 8)
        give_up();
      tick(1);
    end
    for (int n = 0; device_rom_claim_o !== 1'b0; n++)
    begin
      if (n > 200000)
        give_up();
      if (mreads != seen)
      begin
        chk(16'(maddr), 16'(seen));
        chk(16'(mcmd), 16'h0001);
        seen++;
      end
      tick(1);
    end
    tick(2);
    chk(16'(seen), 16'(NUM_WORDS));
    chk(16'({rom_select_oe_n_o, rom_clock_oe_n_o, rom_serial_line_oe_n_o, wait_for_key_o}), 16'h000F);
    chk(16'(mode_o), 16'h0001);
    chk(mem_base_o[0] | mem_base_o[1] | mem_upper_o[0] | mem_upper_o[1], 16'h0000);
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      chk(io_base_o[i], BASE_EXP[i]);
      chk(16'(io_size_o[i]), 16'(SIZE_EXP[i]));
      chk(16'(irq_level_o[i]), 16'(IRQ_EXP[i]));
      chk(16'(dma_map_o[i]), 16'(MAP_EXP[i]));
    end
    chk(16'(dma_channel_o), 16'h001D);
    chk(16'(active_o), 16'h000F);
    chk(16'(dma_pair_enable_o), 16'h001F);
    $display("test default load done");
    for (int i = 0; i < 6; i++)
      io_rd(RD_TAB[i][17:2], RD_TAB[i][1:0]);
    $display("test read enables done");
    want = 1'b0;
    tick(4);
    wake_i = 1'b1;
    tick(1);
    wake_i = 1'b0;
    for (int n = 0; resource_valid_o !== 1'b1; n++)
    begin
      if (n > 20000)
        give_up();
      tick(1);
    end
    chk(resource_word_o, 16'hA55A);
    chk(16'(maddr), 16'(ADDR_RESOURCE));
    chk(16'(wait_for_key_o), 16'h0000);
    $display("test wake read done");
    summarize();
  end
endmodule // pdlr_loader_test
`default_nettype wire
